// ---- rtl/tc_pkg.sv ----
// tc_pkg: constants and types of the dual timer/counter
package tc_pkg;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam int          TC_ADDR_W     = 3;
    localparam int          TC_DATA_W     = 8;
    localparam logic [2:0]  TC_OFS_CTRL   = 3'h0;
    localparam logic [2:0]  TC_OFS_MODE   = 3'h1;
    localparam logic [2:0]  TC_OFS_T0L    = 3'h2;
    localparam logic [2:0]  TC_OFS_T0H    = 3'h3;
    localparam logic [2:0]  TC_OFS_T1L    = 3'h4;
    localparam logic [2:0]  TC_OFS_T1H    = 3'h5;
    localparam logic [2:0]  TC_OFS_IRQEN  = 3'h6;
    localparam logic [7:0]  TC_RST_VAL    = 8'h00;
    // control register bits
    localparam int TC_C_T1_FLAG  = 7;
    localparam int TC_C_T1_RUN   = 6;
    localparam int TC_C_T0_FLAG  = 5;
    localparam int TC_C_T0_RUN   = 4;
    localparam int TC_C_X1_FLAG  = 3;
    localparam int TC_C_X1_EDGE  = 2;
    localparam int TC_C_X0_FLAG  = 1;
    localparam int TC_C_X0_EDGE  = 0;
    // mode register: one nibble per timer
    localparam int TC_M_T0_LSB   = 0;
    localparam int TC_M_T1_LSB   = 4;
    localparam int TC_M_GATE     = 3;
    localparam int TC_M_CSEL     = 2;
    // interrupt enable register bits
    localparam int TC_IE_T0      = 0;
    localparam int TC_IE_T1      = 1;
    localparam int TC_IE_GLOBAL  = 7;
    // ---------------------------------------------------------------
    // timing and count limits
    // ---------------------------------------------------------------
    localparam int          TC_CLK_NS       = 100;
    localparam int          TC_PER_CYCLE_NS = 600;
    localparam int          TC_PER_DIV      = TC_PER_CYCLE_NS / TC_CLK_NS;
    localparam int          TC_DIV_W        = 3;
    localparam logic [4:0]  TC_PRE_MAX      = 5'h1f;
    localparam logic [7:0]  TC_BYTE_MAX     = 8'hff;
    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        TC_MODE13  = 2'b00,
        TC_MODE16  = 2'b01,
        TC_RELOAD  = 2'b10,
        TC_SPLIT   = 2'b11
    } tc_mode_t;
    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
        logic       ovf;
    } tc_cnt_t;
    typedef struct packed {
        logic [TC_DIV_W-1:0] cnt;
        logic                tick;
        logic                s0;
        logic                s1;
        logic                ev0;
        logic                ev1;
    } tc_div_t;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] mode;
        logic [7:0] t0l;
        logic [7:0] t0h;
        logic [7:0] t1l;
        logic [7:0] t1h;
        logic [7:0] irq_en;
        logic [7:0] rdata;
        logic       pin_a;
        logic       pin_b;
        logic       baud;
    } tc_state_t;
endpackage

// ---- rtl/tc_tick_gen.sv ----
// tc_tick_gen: peripheral cycle divider and count pin sampler
`timescale 1ns/10ps
`default_nettype none
module tc_tick_gen
    import tc_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic t0_count_pin,
    input  wire logic t1_count_pin,
    tc_tick_if.src    tk
);
    tc_div_t q;
    tc_div_t d;
    logic    last;

    // ---------------------------------------------------------------
    // divide by six, sample pins once per peripheral cycle
    // ---------------------------------------------------------------
    always_comb begin
        d      = q;
        last   = (q.cnt == TC_DIV_W'(TC_PER_DIV - 1));
        d.cnt  = last ? '0 : q.cnt + 1'b1;
        d.tick = last;
        d.ev0  = last && q.s0 && !t0_count_pin;
        d.ev1  = last && q.s1 && !t1_count_pin;
        if (last) begin
            d.s0 = t0_count_pin;
            d.s1 = t1_count_pin;
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tk.tick    = q.tick;
    assign tk.cnt_ev0 = q.ev0;
    assign tk.cnt_ev1 = q.ev1;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_tick_period: assert property (@(posedge core_clk) disable iff (!rst_n)
        q.tick |=> !q.tick [*5] ##1 q.tick)
        else $error("tick spacing is not six clocks");
    a_pin_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
        (last && q.s1 && !t1_count_pin) |=> q.ev1 ##1 !q.ev1)
        else $error("count pin fall not reported");
endmodule
`default_nettype wire

// ---- rtl/tc_tick_if.sv ----
// tc_tick_if: peripheral cycle tick and count pin events
`timescale 1ns/10ps
`default_nettype none
interface tc_tick_if;
    logic tick;
    logic cnt_ev0;
    logic cnt_ev1;
    modport src (output tick, output cnt_ev0, output cnt_ev1);
    modport snk (input tick, input cnt_ev0, input cnt_ev1);
endinterface
`default_nettype wire

// ---- rtl/tc_timer_top.sv ----
// tc_timer_top: two timer/counters with four modes and register port
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module tc_timer_top
    import tc_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire logic [TC_ADDR_W-1:0] reg_addr,
    input  wire logic [TC_DATA_W-1:0] reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [TC_DATA_W-1:0] reg_rdata,
    input  wire logic                 t0_count_pin,
    input  wire logic                 t1_count_pin,
    input  wire logic                 ext_irq_pin_a_n,
    input  wire logic                 ext_irq_pin_b_n,
    input  wire logic                 t0_irq_ack,
    input  wire logic                 t1_irq_ack,
    output logic                      t0_irq_req,
    output logic                      t1_irq_req,
    output logic                      t1_baud_tick
);
    tc_tick_if tk ();

    tc_state_t q;
    tc_state_t d;
    tc_mode_t  t0_mode;
    tc_mode_t  t1_mode;
    tc_cnt_t   c0;
    tc_cnt_t   c1;
    logic      split0;
    logic      t0_pin_gating;
    logic      t1_pin_gating;
    logic      en0;
    logic      en1;
    logic      h0_inc;
    logic      h0_ovf;
    logic      set0;
    logic      set1;
    logic      x0_set;
    logic      x1_set;

    // ---------------------------------------------------------------
    // tick and count pin events
    // ---------------------------------------------------------------
    tc_tick_gen u_tick (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .t0_count_pin (t0_count_pin),
        .t1_count_pin (t1_count_pin),
        .tk           (tk)
    );

    // ---------------------------------------------------------------
    // one counting step of a timer in modes 0 to 2, split low byte
    // ---------------------------------------------------------------
    function automatic tc_cnt_t tc_step(
        input tc_mode_t   m,
        input logic [7:0] lo,
        input logic [7:0] hi,
        input logic       inc
    );
        tc_cnt_t r;
        r.lo  = lo;
        r.hi  = hi;
        r.ovf = 1'b0;
        if (inc) begin
            case (m)
                TC_MODE13: begin
                    // upper three low bits left alone
                    r.lo[4:0] = lo[4:0] + 5'h01;
                    if (lo[4:0] == TC_PRE_MAX) begin
                        r.hi  = hi + 8'h01;
                        r.ovf = (hi == TC_BYTE_MAX);
                    end
                end
                TC_MODE16: begin
                    r.lo = lo + 8'h01;
                    if (lo == TC_BYTE_MAX) begin
                        r.hi  = hi + 8'h01;
                        r.ovf = (hi == TC_BYTE_MAX);
                    end
                end
                TC_RELOAD: begin
                    r.lo = lo + 8'h01;
                    if (lo == TC_BYTE_MAX) begin
                        r.lo  = hi;
                        r.ovf = 1'b1;
                    end
                end
                default: begin
                    r.lo  = lo + 8'h01;
                    r.ovf = (lo == TC_BYTE_MAX);
                end
            endcase
        end
        return r;
    endfunction

    // ---------------------------------------------------------------
    // count enables
    // ---------------------------------------------------------------
    // mode fields decode straight from the two bits
    assign t0_mode = tc_mode_t'(q.mode[TC_M_T0_LSB +: 2]);
    assign t1_mode = tc_mode_t'(q.mode[TC_M_T1_LSB +: 2]);
    assign split0  = (t0_mode == TC_SPLIT);
    assign t0_pin_gating   = q.mode[TC_M_T0_LSB + TC_M_GATE];
    assign t1_pin_gating   = q.mode[TC_M_T1_LSB + TC_M_GATE];

    // run, pin gating and source select of timer 0
    assign en0 = q.ctrl[TC_C_T0_RUN]
               && (!t0_pin_gating || ext_irq_pin_a_n)
               && (q.mode[TC_M_T0_LSB + TC_M_CSEL]
                   ? tk.cnt_ev0 : tk.tick);

    // timer 1 loses its run bit to timer 0 in split, halts in its mode 3
    assign en1 = (split0 || q.ctrl[TC_C_T1_RUN])
               && (!t1_pin_gating || ext_irq_pin_b_n)
               && (t1_mode != TC_SPLIT)
               && (q.mode[TC_M_T1_LSB + TC_M_CSEL]
                   ? tk.cnt_ev1 : tk.tick);

    // split high byte of timer 0 runs on ticks under timer 1 run
    assign h0_inc = split0 && q.ctrl[TC_C_T1_RUN] && tk.tick;
    assign h0_ovf = h0_inc && (q.t0h == TC_BYTE_MAX);

    assign c0 = tc_step(t0_mode, q.t0l, q.t0h, en0);
    assign c1 = tc_step(t1_mode, q.t1l, q.t1h, en1);

    // flag sources; in split timer 1 overflow raises no flag
    assign set0 = c0.ovf;
    assign set1 = split0 ? h0_ovf : c1.ovf;

    // external pin flags: falling edge or low level
    assign x0_set = q.ctrl[TC_C_X0_EDGE]
                  ? (q.pin_a && !ext_irq_pin_a_n) : !ext_irq_pin_a_n;
    assign x1_set = q.ctrl[TC_C_X1_EDGE]
                  ? (q.pin_b && !ext_irq_pin_b_n) : !ext_irq_pin_b_n;

    // ---------------------------------------------------------------
    // next state: counting, register writes, flags, read data
    // ---------------------------------------------------------------
    always_comb begin
        d       = q;
        d.pin_a = ext_irq_pin_a_n;
        d.pin_b = ext_irq_pin_b_n;
        d.t0l   = c0.lo;
        d.t0h   = split0 ? (h0_inc ? q.t0h + 8'h01 : q.t0h) : c0.hi;
        d.t1l   = c1.lo;
        d.t1h   = c1.hi;
        d.baud  = c1.ovf;
        d.rdata = TC_RST_VAL;
        // vectoring clears the overflow flags
        if (t0_irq_ack) begin
            d.ctrl[TC_C_T0_FLAG] = 1'b0;
        end
        if (t1_irq_ack) begin
            d.ctrl[TC_C_T1_FLAG] = 1'b0;
        end
        // software writes; count bytes overwrite the count step
        if (reg_wr) begin
            if (reg_addr == TC_OFS_CTRL) begin
                d.ctrl = reg_wdata;
            end else if (reg_addr == TC_OFS_MODE) begin
                d.mode = reg_wdata;
            end else if (reg_addr == TC_OFS_T0L) begin
                d.t0l = reg_wdata;
            end else if (reg_addr == TC_OFS_T0H) begin
                d.t0h = reg_wdata;
            end else if (reg_addr == TC_OFS_T1L) begin
                d.t1l = reg_wdata;
            end else if (reg_addr == TC_OFS_T1H) begin
                d.t1h = reg_wdata;
            end else if (reg_addr == TC_OFS_IRQEN) begin
                d.irq_en = reg_wdata;
            end
        end
        // hardware sets win over any clear in the same cycle
        if (set0) begin
            d.ctrl[TC_C_T0_FLAG] = 1'b1;
        end
        if (set1) begin
            d.ctrl[TC_C_T1_FLAG] = 1'b1;
        end
        if (x0_set) begin
            d.ctrl[TC_C_X0_FLAG] = 1'b1;
        end
        if (x1_set) begin
            d.ctrl[TC_C_X1_FLAG] = 1'b1;
        end
        // read data for the next cycle only
        if (reg_rd) begin
            if (reg_addr == TC_OFS_CTRL) begin
                d.rdata = q.ctrl;
            end else if (reg_addr == TC_OFS_MODE) begin
                d.rdata = q.mode;
            end else if (reg_addr == TC_OFS_T0L) begin
                d.rdata = q.t0l;
            end else if (reg_addr == TC_OFS_T0H) begin
                d.rdata = q.t0h;
            end else if (reg_addr == TC_OFS_T1L) begin
                d.rdata = q.t1l;
            end else if (reg_addr == TC_OFS_T1H) begin
                d.rdata = q.t1h;
            end else if (reg_addr == TC_OFS_IRQEN) begin
                d.rdata = q.irq_en;
            end
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign reg_rdata    = q.rdata;
    assign t1_baud_tick = q.baud;
    // flag gated by own enable and the global enable
    assign t0_irq_req = q.ctrl[TC_C_T0_FLAG] && q.irq_en[TC_IE_T0]
                      && q.irq_en[TC_IE_GLOBAL];
    assign t1_irq_req = q.ctrl[TC_C_T1_FLAG] && q.irq_en[TC_IE_T1]
                      && q.irq_en[TC_IE_GLOBAL];

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_m0_carry: assert property (
        (t0_mode == TC_MODE13 && en0 && !reg_wr
         && q.t0l[4:0] == TC_PRE_MAX)
        |=> q.t0h == $past(q.t0h) + 8'h01 && q.t0l[4:0] == 5'h00)
        else $error("mode 0 prescaler carry wrong");
    a_m1_cascade: assert property (
        (t1_mode == TC_MODE16 && en1 && !reg_wr
         && q.t1l == TC_BYTE_MAX)
        |=> q.t1h == $past(q.t1h) + 8'h01 && q.t1l == 8'h00)
        else $error("mode 1 cascade wrong");
    a_m2_reload: assert property (
        (t0_mode == TC_RELOAD && en0 && !reg_wr
         && q.t0l == TC_BYTE_MAX)
        |=> q.t0l == $past(q.t0h) && $stable(q.t0h)
            && q.ctrl[TC_C_T0_FLAG])
        else $error("mode 2 reload wrong");
    a_split_high: assert property (
        (split0 && q.ctrl[TC_C_T1_RUN] && tk.tick && !reg_wr)
        |=> q.t0h == $past(q.t0h) + 8'h01)
        else $error("split high byte did not count");
    a_t1_halt: assert property (
        (t1_mode == TC_SPLIT && !reg_wr)
        |=> $stable(q.t1l) && $stable(q.t1h))
        else $error("timer 1 moved while halted");
    a_gate_block: assert property (
        (t1_pin_gating && !ext_irq_pin_b_n && !reg_wr)
        |=> $stable(q.t1l) && $stable(q.t1h))
        else $error("gated timer 1 counted with pin low");
    a_flag_ack: assert property (
        (t0_irq_ack && !set0 && !reg_wr) |=> !q.ctrl[TC_C_T0_FLAG])
        else $error("vectoring did not clear flag");
    a_flag_set: assert property (
        set1 |=> q.ctrl[TC_C_T1_FLAG] ##0 (t1_irq_req ==
            (q.irq_en[TC_IE_T1] && q.irq_en[TC_IE_GLOBAL])))
        else $error("overflow flag or request missing");
    a_baud_out: assert property (
        (c1.ovf) |=> t1_baud_tick ##1 !t1_baud_tick)
        else $error("baud tick not one pulse");
    a_read_one: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");

    c_t0_ovf:   cover property (set0 && t0_mode == TC_MODE13);
    c_reload:   cover property (c1.ovf && t1_mode == TC_RELOAD);
    c_split:    cover property (h0_ovf);
    c_ack_race: cover property (t0_irq_ack && set0);
endmodule
`default_nettype wire

// ---- verification/tc_pin_model.sv ----
// tc_pin_model: far side pins, count pulses and gate levels
`timescale 1ns/10ps
`default_nettype none
module tc_pin_model (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic [3:0] n_pulses,
    input  wire logic       gate_b,
    output logic            cnt_pin,
    output logic            pin_a_n,
    output logic            pin_b_n,
    output logic            done
);
    logic [4:0] ph_q;
    logic [3:0] left_q;

    // --------------------------------------------------------------
    // pulse train
    // --------------------------------------------------------------
    // each level held 12 clocks, so every level is sampled at least once
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_q    <= 5'h00;
            left_q  <= 4'h0;
            cnt_pin <= 1'b1;
        end else if (start) begin
            ph_q   <= 5'h00;
            left_q <= n_pulses;
        end else if (left_q != 4'h0) begin
            ph_q <= ph_q + 5'h01;
            if (ph_q == 5'h0b) begin
                cnt_pin <= 1'b0;
            end
            if (ph_q == 5'h17) begin
                cnt_pin <= 1'b1;
                ph_q    <= 5'h00;
                left_q  <= left_q - 4'h1;
            end
        end
    end

    // gate pins: pin a kept high, pin b follows the bench
    assign pin_a_n = 1'b1;
    assign pin_b_n = gate_b;
    assign done    = (left_q == 4'h0);
endmodule
`default_nettype wire

// ---- verification/test_dual_timer_counter_modes.sv ----
// test_dual_timer_counter_modes: self-checking bench of the timer block
`timescale 1ns/10ps
`default_nettype none
module test_dual_timer_counter_modes import tc_pkg::*;;
    logic                 core_clk;
    logic                 rst_n;
    logic [TC_ADDR_W-1:0] reg_addr;
    logic [TC_DATA_W-1:0] reg_wdata;
    logic                 reg_wr;
    logic                 reg_rd;
    logic [TC_DATA_W-1:0] reg_rdata;
    logic                 t1_pin;
    logic                 pin_a_n;
    logic                 pin_b_n;
    logic                 t0_ack;
    logic                 t1_ack;
    logic                 t0_req;
    logic                 t1_req;
    logic                 baud;
    logic                 start;
    logic [3:0]           n_pulses;
    logic                 gate_b;
    logic                 done;
    int                   n_errors;
    int                   compares;
    int                   n;
    logic [31:0]          seed;
    logic [7:0]           v;
    logic [7:0]           s;
    logic [3:0]           k;

    tc_timer_top DUT (.core_clk(core_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .t0_count_pin(1'b1),
        .t1_count_pin(t1_pin), .ext_irq_pin_a_n(pin_a_n),
        .ext_irq_pin_b_n(pin_b_n), .t0_irq_ack(t0_ack),
        .t1_irq_ack(t1_ack), .t0_irq_req(t0_req), .t1_irq_req(t1_req),
        .t1_baud_tick(baud));
    tc_pin_model u_pins (.core_clk(core_clk), .rst_n(rst_n),
        .start(start), .n_pulses(n_pulses), .gate_b(gate_b),
        .cnt_pin(t1_pin), .pin_a_n(pin_a_n), .pin_b_n(pin_b_n),
        .done(done));

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    always #50 core_clk = ~core_clk;

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    task automatic close_out();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: byte %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk1(input logic g, input logic e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: bit %b exp %b", $time, g, e);
        end
    endtask

    // one write cycle, then strobe released
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stands in the cycle after the strobe only
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        // data launched at this edge, taken once settled mid-cycle
        @(negedge core_clk);
        d = reg_rdata;
    endtask

    // bounded wait: 0 req0, 1 req1, 2 baud, 3 pulses done
    task automatic wait_sig(input int w);
        n = 0;
        @(negedge core_clk);
        while ((w == 0 ? t0_req : w == 1 ? t1_req : w == 2 ? baud : done)
               !== 1'b1) begin
            @(negedge core_clk);
            n++;
            if (n > 2000) begin
                n_errors++;
                $display("wrong value at %0t: wait ran out", $time);
                close_out();
            end
        end
    endtask

    task automatic ack(input logic w);
        @(posedge core_clk);
        t0_ack <= !w;
        t1_ack <= w;
        @(posedge core_clk);
        t0_ack <= 1'b0;
        t1_ack <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic pulses(input logic [3:0] c);
        start    <= 1'b1;
        n_pulses <= c;
        @(posedge core_clk);
        start <= 1'b0;
        @(posedge core_clk);
        wait_sig(3);
        repeat (14) @(posedge core_clk);
    endtask

    // --------------------------------------------------------------
    // main sequence; run cleared before every mode change and every preset change except the second mode 2 reload value
    // --------------------------------------------------------------
    initial begin
        core_clk = 1'b0; rst_n = 1'b0; reg_addr = 3'h0; reg_wdata = 8'h00;
        reg_wr = 1'b0; reg_rd = 1'b0; t0_ack = 1'b0; t1_ack = 1'b0;
        start = 1'b0; n_pulses = 4'h0; gate_b = 1'b1;
        n_errors = 0; compares = 0; seed = 32'h5130;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        wr(3'h7, 8'hff);
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), v);
            chk8(v, TC_RST_VAL);
        end
        $display("test reset done");
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h01);
        wr(3'h2, 8'hff);
        wr(3'h3, 8'hff);
        wr(3'h6, 8'h81);
        wr(3'h0, 8'h10);
        wait_sig(0);
        rd(3'h2, v); chk8(v, 8'h00);
        rd(3'h3, v); chk8(v, 8'h00);
        ack(1'b0); chk1(t0_req, 1'b0);
        $display("test mode1 done");
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h00);
        wr(3'h2, 8'hff);
        wr(3'h3, 8'hff);
        wr(3'h0, 8'h10);
        wait_sig(0);
        rd(3'h2, v); chk8(v, 8'he0);
        rd(3'h3, v); chk8(v, 8'h00);
        $display("test mode0 done");
        seed = xs(seed);
        s = {2'b10, seed[5:0]};
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h02);
        wr(3'h3, s);
        wr(3'h2, 8'hff);
        wr(3'h0, 8'h10);
        wait_sig(0);
        rd(3'h2, v); chk8(v, s);
        rd(3'h3, v); chk8(v, s);
        wr(3'h6, 8'h01);
        @(posedge core_clk); chk1(t0_req, 1'b0);
        wr(3'h6, 8'h81);
        @(posedge core_clk); chk1(t0_req, 1'b1);
        s = {2'b10, seed[13:8]};
        wr(3'h3, s);
        ack(1'b0);
        wait_sig(0);
        rd(3'h2, v); chk8(v, s);
        $display("test reload done");
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h20);
        wr(3'h5, 8'hff);
        wr(3'h4, 8'hff);
        wr(3'h6, 8'h82);
        wr(3'h0, 8'h40);
        wait_sig(2);
        @(posedge core_clk);
        wait_sig(2);
        chk8(8'(n + 1), 8'(TC_PER_DIV));
        chk1(t1_req, 1'b1);
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h30);
        wr(3'h4, 8'h00);
        wr(3'h0, 8'h40);
        repeat (40) @(posedge core_clk);
        rd(3'h4, v); chk8(v, 8'h00);
        $display("test timer1 done");
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h33);
        wr(3'h3, 8'hff);
        wr(3'h2, 8'h00);
        wr(3'h6, 8'h83);
        wr(3'h0, 8'h40);
        wait_sig(1);
        rd(3'h2, v); chk8(v, 8'h00);
        rd(3'h3, v); chk8(v, 8'h00);
        rd(3'h0, v); chk8(v & 8'ha0, 8'h80);
        rd(3'h4, v); chk8(v, 8'h00);
        ack(1'b1); chk1(t1_req, 1'b0);
        wr(3'h0, 8'h00);
        wr(3'h3, 8'h00);
        wr(3'h2, 8'hff);
        wr(3'h0, 8'h10);
        wait_sig(0);
        rd(3'h2, v); chk8(v, 8'h00);
        rd(3'h3, v); chk8(v, 8'h00);
        $display("test split done");
        seed = xs(seed);
        s = {1'b0, seed[6:0]};
        k = seed[11:8] | 4'h1;
        wr(3'h0, 8'h00);
        wr(3'h1, 8'hd0);
        wr(3'h4, s);
        wr(3'h5, 8'h00);
        gate_b <= 1'b0;
        wr(3'h0, 8'h40);
        pulses(k);
        rd(3'h4, v); chk8(v, s);
        gate_b <= 1'b1;
        pulses(k);
        rd(3'h4, v); chk8(v, s + 8'(k));
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h50);
        gate_b <= 1'b0;
        wr(3'h0, 8'h40);
        pulses(k);
        rd(3'h4, v); chk8(v, s + 8'(2 * k));
        $display("test counter done");
        close_out();
    end
endmodule
`default_nettype wire
